//--- hw/sysref_multi_device_sync_ctrl.v
// register file and lock logic of the multiple-device synchronization unit
`timescale 1ns/100ps
`include "sync_ctrl_defs.vh"

// Contract
// - east buffer powered only when bit five set
// - west buffer powered only when bit four set
// - east termination active when bit two set
// - west termination active when bit zero set
// - oscillator sync only when bit six set
// - automatic mode starts search at programmed delay
// - manual mode applies programmed delay directly
// - relock after lockout when relock bit set
// - lock after qualify-count plus one consecutive equal checks
// - signed offset delays data flow in clocks
// - window low time from eight-bit value
// - window high time from eight-bit value
// - multiframe clock period from eight-bit value
// - multiframe clock delayed by preset after reference
// - applied adjust delay readable, read only
// - delay mode bit one manual, zero automatic
// - two-bit code picks the lock criterion
// - side select one east, zero west
// - lock flag bit seven set on lock
module sysref_multi_device_sync_ctrl #(
	parameter DW = 8                   // register and delay width
) (
	input  wire          clk,                     // dac clock, 100 MHz
	input  wire          rst,                     // asynchronous reset, active high
	// register port
	input  wire [7:0]    reg_addr,                // register address
	input  wire [DW-1:0] reg_wdata,               // register write data
	input  wire          reg_wr,                  // write strobe, one cycle
	input  wire          reg_rd,                  // read strobe, one cycle
	output reg  [DW-1:0] reg_rdata_r,             // read data, valid cycle after strobe
	// reference lines and detector conditions
	input  wire          east_ref_in,             // east alignment reference, synchronous
	input  wire          west_ref_in,             // west alignment reference, synchronous
	input  wire          early_det,               // detector early condition
	input  wire          late_det,                // detector late condition
	input  wire          start_early_det,         // detector start-early condition
	input  wire          start_late_det,          // detector start-late condition
	input  wire          lockout,                 // detector reports lockout
	input  wire          data_in_valid,           // sample strobe entering data path
	// pin controls, pulses and status
	output reg           east_ref_buffer_power,   // east input buffer power
	output reg           west_ref_buffer_power,   // west input buffer power
	output reg           east_ref_termination_on, // east termination enable
	output reg           west_ref_termination_on, // west termination enable
	output reg           osc_sync_pulse_r,        // oscillator synchronization pulse
	output reg           ref_pulse_r,             // internal reference pulse
	output reg           window_out_r,            // evaluation window level
	output reg           mf_clock_tick_r,         // multiframe clock boundary
	output reg           data_out_valid_r,        // sample strobe after offset delay
	output reg  [DW-1:0] applied_adjust_delay,    // adjustment delay in use
	output reg           sync_locked_flag         // lock achieved
);

	// lock state codes, binary
	// out is the locked-out wait
	localparam [1:0] ST_IDLE   = 2'h0;   // sync disabled
	localparam [1:0] ST_SEARCH = 2'h1;   // stepping adjustment delay
	localparam [1:0] ST_LOCKED = 2'h2;   // lock held
	localparam [1:0] ST_OUT    = 2'h3;   // locked out, waiting

	// one flop per clock of delay; 256 taps
	// cover the signed range around 128
	// area traded for a line that can hold
	// any number of strobes in flight
	localparam OFS_SPAN = 256;           // depth of offset delay line

	// register copies, reserved bits zero
	reg [DW-1:0] io_ctrl_r;       // buffer and termination controls
	reg [DW-1:0] misc_a_r;        // oscillator sync control
	reg [DW-1:0] adj_prog_r;      // programmed adjustment delay
	reg [DW-1:0] misc_b_r;        // relock and qualify count
	reg [DW-1:0] offset_r;        // signed data-flow offset
	reg [DW-1:0] win_low_r;       // window low time
	reg [DW-1:0] win_high_r;      // window high time
	reg [DW-1:0] mf_period_r;     // multiframe period
	reg [DW-1:0] mf_preset_r;     // multiframe preset
	reg [DW-1:0] main_r;          // enable, side, mode, criterion

	// lock machine and edge detector
	reg [1:0]    state_r;         // lock state
	reg [1:0]    state_nxt;       // next lock state
	reg [3:0]    qual_cnt_r;      // consecutive equal checks
	reg          ref_prev_r;      // selected input last clock
	// strobe history for the offset tap
	reg [OFS_SPAN-1:0] dline_r;   // valid delay line

	// decoded control fields
	// all taken live from the registers
	wire         sync_en   = main_r[`BIT_SYNC_EN];       // sync function enabled
	wire         manual    = main_r[`BIT_MANUAL];
	wire [1:0]   criterion = main_r[7:6];                // lock criterion code
	wire [3:0]   qual_need = misc_b_r[3:0];              // lock qualify count
	wire         relock_en = misc_b_r[`BIT_RELOCK];      // relock on lockout

	// timer results and decode outputs
	wire         win_level;                              // timer window
	wire         mf_tick;                                // timer multiframe tick
	reg          eq_check;                               // criterion met this clock
	reg          ref_sel;                                // selected reference input

	// selected reference side; a side change
	// while the new line is high reads as an
	// edge, so switch sides only when disabled
	always @* begin
		ref_sel = main_r[`BIT_SIDE_SEL] ? east_ref_in : west_ref_in;
	end

	// rising edge of the selected input becomes the internal reference pulse
	// last level resets low like an idle line,
	// so no false pulse follows reset
	// gated by the enable: an edge while disabled
	// never restarts the multiframe clock
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_prev_r  <= 1'b0;
			ref_pulse_r <= 1'b0;
		end else begin
			ref_prev_r  <= ref_sel;
			ref_pulse_r <= sync_en & ref_sel & ~ref_prev_r;
		end
	end

	// lock criterion decode
	// one level test per code, no history
	always @* begin
		case (criterion)
			`CRIT_BOTH:   eq_check = early_det & late_det;
			`CRIT_LATE:   eq_check = late_det;
			`CRIT_EARLY:  eq_check = early_det;
			`CRIT_EITHER: eq_check = (start_early_det & late_det) |
			                         (start_late_det & early_det);
			default:      eq_check = 1'b0;
		endcase
	end

	// checks are only evaluated while the window is high
	// and only at multiframe boundaries, so a
	// long period also slows the search
	// a zero qualify count locks on first match
	wire check_now = win_level & mf_tick;       // one evaluation per multiframe in window
	wire qual_done = (qual_cnt_r >= qual_need);  // enough equal checks seen

	// lock state next value
	// disable returns to idle from any state;
	// a lockout without relock parks the
	// machine until it is disabled again
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:   if (sync_en) state_nxt = ST_SEARCH;
			ST_SEARCH: if (!sync_en) state_nxt = ST_IDLE;
			           else if (check_now & eq_check & qual_done) state_nxt = ST_LOCKED;
			ST_LOCKED: if (!sync_en) state_nxt = ST_IDLE;
			           else if (lockout) state_nxt = ST_OUT;
			ST_OUT:    if (!sync_en) state_nxt = ST_IDLE;
			           else if (relock_en) state_nxt = ST_SEARCH;
			default:   state_nxt = ST_IDLE;
		endcase
	end

	// lock state, qualify count and applied delay
	// the applied delay wraps past 255 in
	// a long search and keeps stepping
	// a mismatch zeroes the qualify count
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r              <= ST_IDLE;
			qual_cnt_r           <= 4'h0;
			applied_adjust_delay <= `RST_BYTE;
			sync_locked_flag     <= 1'b0;
		end else begin
			state_r          <= state_nxt;
			sync_locked_flag <= (state_nxt == ST_LOCKED);
			if (manual) begin
				// manual mode never steps the delay
				applied_adjust_delay <= adj_prog_r;
				// a fresh search qualifies from zero
				if (state_r != ST_SEARCH || state_nxt != ST_SEARCH)
					qual_cnt_r <= 4'h0;
			end else if (state_r != ST_SEARCH || state_nxt != ST_SEARCH) begin
				// entering a search reloads the start point; leaving one keeps the delay
				if (state_nxt == ST_SEARCH)
					applied_adjust_delay <= adj_prog_r;
				qual_cnt_r <= 4'h0;
			end else if (check_now) begin
				if (eq_check) begin
					// qualify counter saturates; a zero count locks on first match
					if (qual_cnt_r != 4'hf)
						qual_cnt_r <= qual_cnt_r + 1'b1;
				end else begin
					// no match: restart qualification and try the next delay
					qual_cnt_r           <= 4'h0;
					applied_adjust_delay <= applied_adjust_delay + 1'b1;
				end
			end
			// manual search still counts matches
			if (manual && check_now && state_r == ST_SEARCH && state_nxt == ST_SEARCH)
				qual_cnt_r <= eq_check ? ((qual_cnt_r != 4'hf) ? qual_cnt_r + 1'b1 : qual_cnt_r)
				                       : 4'h0;
		end
	end

	// pin controls follow their register bits
	// one flop between register and pin, so
	// a pin follows its write by one clock
	// pins come up off and unterminated
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			east_ref_buffer_power   <= 1'b0;
			west_ref_buffer_power   <= 1'b0;
			east_ref_termination_on <= 1'b0;
			west_ref_termination_on <= 1'b0;
			osc_sync_pulse_r        <= 1'b0;
		end else begin
			east_ref_buffer_power   <= io_ctrl_r[`BIT_EAST_PWR];
			west_ref_buffer_power   <= io_ctrl_r[`BIT_WEST_PWR];
			east_ref_termination_on <= io_ctrl_r[`BIT_EAST_TERM];
			west_ref_termination_on <= io_ctrl_r[`BIT_WEST_TERM];
			// oscillator resync on each reference pulse only when enabled
			osc_sync_pulse_r <= misc_a_r[`BIT_OSC_SYNC] & ref_pulse_r;
		end
	end

	// data-flow offset: delay line tapped at 128 plus the signed offset
	// gives -128..127 relative to the nominal latency of 130 clocks
	// flipping the sign bit maps the signed
	// offset to a tap index with no adder
	// an offset change with strobes in flight
	// may drop or repeat several of them
	wire [DW-1:0] tap = offset_r ^ 8'h80;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			dline_r          <= {OFS_SPAN{1'b0}};
			data_out_valid_r <= 1'b0;
		end else begin
			dline_r          <= {dline_r[OFS_SPAN-2:0], data_in_valid};
			data_out_valid_r <= dline_r[tap];
		end
	end

	// timer outputs registered once more so all ports come from flops
	// the lock logic uses the timer's own
	// outputs, one clock ahead of the pins
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			window_out_r    <= 1'b0;
			mf_clock_tick_r <= 1'b0;
		end else begin
			window_out_r    <= win_level;
			mf_clock_tick_r <= mf_tick;
		end
	end

	// period and preset counts are read live,
	// so reprogram them only while disabled
	// the window is held low while disabled
	sync_window_timer #(
		.W (DW)
	) u_timer (
		.clk       (clk),
		.rst       (rst),
		.run       (sync_en),
		.win_low   (win_low_r),
		.win_high  (win_high_r),
		.mf_period (mf_period_r),
		.mf_preset (mf_preset_r),
		.ref_pulse (ref_pulse_r),
		.window_r  (win_level),
		.mf_tick_r (mf_tick)
	);

	// register writes; reserved bits are masked so they stay zero
	// status addresses fall into the default
	// branch, so writes to them are dropped
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			io_ctrl_r   <= `RST_IO_CTRL;
			misc_a_r    <= `RST_MISC_A;
			adj_prog_r  <= `RST_BYTE;
			misc_b_r    <= `RST_MISC_B;
			offset_r    <= `RST_BYTE;
			win_low_r   <= `RST_BYTE;
			win_high_r  <= `RST_BYTE;
			mf_period_r <= `RST_BYTE;
			mf_preset_r <= `RST_BYTE;
			main_r      <= `RST_BYTE;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_IO_CTRL:   io_ctrl_r   <= reg_wdata & `MASK_IO_CTRL;
				`OFS_MISC_A:    misc_a_r    <= reg_wdata & `MASK_MISC_A;
				`OFS_ADJ_PROG:  adj_prog_r  <= reg_wdata;
				`OFS_MISC_B:    misc_b_r    <= reg_wdata & `MASK_MISC_B;
				`OFS_OFFSET:    offset_r    <= reg_wdata;
				`OFS_WIN_LOW:   win_low_r   <= reg_wdata;
				`OFS_WIN_HIGH:  win_high_r  <= reg_wdata;
				`OFS_MF_PERIOD: mf_period_r <= reg_wdata;
				`OFS_MF_PRESET: mf_preset_r <= reg_wdata;
				`OFS_MAIN:      main_r      <= reg_wdata & `MASK_MAIN;
				default:        ; // writes elsewhere are ignored
			endcase
		end
	end

	// register reads; unmapped addresses read zero
	// data is registered and holds until
	// the next read strobe
	// reading status has no side effect
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_r <= `RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`OFS_IO_CTRL:    reg_rdata_r <= io_ctrl_r;
				`OFS_MISC_A:     reg_rdata_r <= misc_a_r;
				`OFS_ADJ_PROG:   reg_rdata_r <= adj_prog_r;
				`OFS_MISC_B:     reg_rdata_r <= misc_b_r;
				`OFS_OFFSET:     reg_rdata_r <= offset_r;
				`OFS_WIN_LOW:    reg_rdata_r <= win_low_r;
				`OFS_WIN_HIGH:   reg_rdata_r <= win_high_r;
				`OFS_MF_PERIOD:  reg_rdata_r <= mf_period_r;
				`OFS_MF_PRESET:  reg_rdata_r <= mf_preset_r;
				`OFS_MAIN:       reg_rdata_r <= main_r;
				`OFS_ADJ_ACTUAL: reg_rdata_r <= applied_adjust_delay;
				`OFS_LOCK_STAT:  reg_rdata_r <= {sync_locked_flag, 7'h00};
				default:         reg_rdata_r <= `RST_BYTE;
			endcase
		end
	end

endmodule // sysref_multi_device_sync_ctrl

//--- hw/sync_ctrl_defs.vh
// register offsets, field positions, masks, reset values and criterion codes for the sync control block
`ifndef SYNC_CTRL_DEFS_VH
`define SYNC_CTRL_DEFS_VH

// register offsets (byte addresses on the register port)
`define OFS_IO_CTRL      8'ha2
`define OFS_MISC_A       8'ha3
`define OFS_ADJ_PROG     8'ha4
`define OFS_MISC_B       8'ha6
`define OFS_OFFSET       8'ha7
`define OFS_WIN_LOW      8'ha8
`define OFS_WIN_HIGH     8'ha9
`define OFS_MF_PERIOD    8'haa
`define OFS_MF_PRESET    8'hab
`define OFS_ADJ_ACTUAL   8'hb5
`define OFS_MAIN         8'ha0
`define OFS_LOCK_STAT    8'hb8

// field positions
`define BIT_EAST_PWR     5
`define BIT_WEST_PWR     4
`define BIT_EAST_TERM    2
`define BIT_WEST_TERM    0
`define BIT_OSC_SYNC     6
`define BIT_RELOCK       4
`define BIT_LOCK_FLAG    7
`define BIT_MANUAL       5
`define BIT_SIDE_SEL     3
`define BIT_SYNC_EN      0

// writable masks; bits outside each mask read as zero
`define MASK_IO_CTRL     8'h35
`define MASK_MISC_A      8'h7f
`define MASK_MISC_B      8'h1f
`define MASK_MAIN        8'hff

// reset values
`define RST_IO_CTRL      8'h00
`define RST_MISC_A       8'h10
`define RST_MISC_B       8'h00
`define RST_BYTE         8'h00

// lock criterion codes
`define CRIT_BOTH        2'h0
`define CRIT_LATE        2'h1
`define CRIT_EARLY       2'h2
`define CRIT_EITHER      2'h3

`endif

//--- hw/sync_window_timer.v
// evaluation window and multiframe clock timing generator
`timescale 1ns/100ps
module sync_window_timer #(
	parameter W = 8                  // width of the period counts
) (
	input  wire         clk,          // dac clock
	input  wire         rst,          // asynchronous reset, active high
	input  wire         run,          // timing runs while high
	input  wire [W-1:0] win_low,      // window low time in clocks
	input  wire [W-1:0] win_high,     // window high time in clocks
	input  wire [W-1:0] mf_period,    // multiframe clock period in clocks
	input  wire [W-1:0] mf_preset,    // multiframe clock delay after ref
	input  wire         ref_pulse,    // internal reference pulse
	output reg          window_r,     // evaluation window level
	output reg          mf_tick_r     // multiframe clock boundary pulse
);

	reg [W-1:0] win_cnt_r;        // clocks left in current window phase
	reg [W-1:0] mf_cnt_r;         // position inside multiframe period
	reg [W-1:0] pre_cnt_r;        // preset countdown after a ref pulse
	reg         pre_busy_r;       // preset countdown running

	// window alternates low and high phases; zero times count as one clock
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			window_r  <= 1'b0;
			win_cnt_r <= {W{1'b0}};
		end else if (!run) begin
			window_r  <= 1'b0;
			win_cnt_r <= win_low;
		end else if (win_cnt_r == {W{1'b0}}) begin
			window_r  <= ~window_r;
			win_cnt_r <= window_r ? win_low : win_high;
		end else begin
			win_cnt_r <= win_cnt_r - 1'b1;
		end
	end

	// multiframe counter restarts preset plus one clocks after each reference pulse
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mf_cnt_r   <= {W{1'b0}};
			pre_cnt_r  <= {W{1'b0}};
			pre_busy_r <= 1'b0;
			mf_tick_r  <= 1'b0;
		end else begin
			mf_tick_r <= 1'b0;
			if (ref_pulse) begin
				pre_cnt_r  <= mf_preset;
				pre_busy_r <= 1'b1;
			end else if (pre_busy_r) begin
				if (pre_cnt_r == {W{1'b0}}) begin
					pre_busy_r <= 1'b0;
					mf_cnt_r   <= {W{1'b0}};
					mf_tick_r  <= 1'b1;
				end else begin
					pre_cnt_r <= pre_cnt_r - 1'b1;
				end
			end else if (run) begin
				// period value is the last count index, so a zero period ticks every clock
				if (mf_cnt_r >= mf_period) begin
					mf_cnt_r  <= {W{1'b0}};
					mf_tick_r <= 1'b1;
				end else begin
					mf_cnt_r <= mf_cnt_r + 1'b1;
				end
			end
		end
	end

endmodule // sync_window_timer

//--- verif/sync_ctrl_properties.sv
// port assertions for the multiple-device sync control block
`timescale 1ns/100ps
module sync_ctrl_properties #(
	parameter DW = 8                          // register width
) (
	input wire          clk,                  // dac clock
	input wire          rst,                  // async reset
	input wire [7:0]    reg_addr,             // register address
	input wire [DW-1:0] reg_wdata,            // write data
	input wire          reg_wr,               // write strobe
	input wire          reg_rd,               // read strobe
	input wire [DW-1:0] reg_rdata_r,          // read data
	input wire          east_ref_in,          // east reference
	input wire          west_ref_in,          // west reference
	input wire          east_ref_buffer_power,   // east buffer
	input wire          west_ref_buffer_power,   // west buffer
	input wire          east_ref_termination_on, // east term
	input wire          west_ref_termination_on, // west term
	input wire          osc_sync_pulse_r,     // oscillator sync
	input wire          ref_pulse_r,          // reference pulse
	input wire [DW-1:0] applied_adjust_delay, // delay in use
	input wire          sync_locked_flag      // lock flag
);
	reg          pe_r, pw_r, man_r; // last ref levels, manual shadow
	reg [DW-1:0] prog_r;            // programmed delay shadow
	wire         io_wr = reg_wr && reg_addr == 8'ha2; // io byte write
	// shadows kept here since the block hides its registers
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pe_r <= 1'b0;
			pw_r <= 1'b0;
			man_r <= 1'b0;
			prog_r <= 8'h00;
		end else begin
			pe_r <= east_ref_in;
			pw_r <= west_ref_in;
			if (reg_wr && reg_addr == 8'ha0) man_r <= reg_wdata[5];
			if (reg_wr && reg_addr == 8'ha4) prog_r <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_EAST_PWR: assert property (io_wr |-> ##2 east_ref_buffer_power == $past(reg_wdata[5], 2))
		else $error("east buffer power wrong");
	AST_WEST_PWR: assert property (io_wr |-> ##2 west_ref_buffer_power == $past(reg_wdata[4], 2))
		else $error("west buffer power wrong");
	AST_EAST_TERM: assert property (io_wr |-> ##2 east_ref_termination_on == $past(reg_wdata[2], 2))
		else $error("east termination wrong");
	AST_WEST_TERM: assert property (io_wr |-> ##2 west_ref_termination_on == $past(reg_wdata[0], 2))
		else $error("west termination wrong");
	AST_OSC_AFTER_REF: assert property (osc_sync_pulse_r |-> $past(ref_pulse_r))
		else $error("oscillator pulse without reference");
	AST_REF_ON_RISE: assert property (ref_pulse_r |-> $past(east_ref_in & ~pe_r | west_ref_in & ~pw_r))
		else $error("reference pulse without input edge");
	AST_ADJ_READ: assert property (reg_rd && reg_addr == 8'hb5 |=> reg_rdata_r == $past(applied_adjust_delay))
		else $error("applied delay readback wrong");
	AST_LOCK_READ: assert property (reg_rd && reg_addr == 8'hb8 |=> reg_rdata_r == {$past(sync_locked_flag), 7'h00})
		else $error("lock status readback wrong");
	AST_MANUAL_DELAY: assert property (man_r && $past(man_r, 3) && prog_r == $past(prog_r, 3) |-> applied_adjust_delay == prog_r)
		else $error("manual delay not applied");
	COV_LOCK: cover property ($rose(sync_locked_flag));
	COV_OSC: cover property (osc_sync_pulse_r);
	COV_MAN_READ: cover property (man_r && reg_rd && reg_addr == 8'hb5);
endmodule // sync_ctrl_properties

bind sysref_multi_device_sync_ctrl sync_ctrl_properties #(.DW(DW)) props_inst (.clk, .rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .east_ref_in, .west_ref_in,
	.east_ref_buffer_power, .west_ref_buffer_power, .east_ref_termination_on,
	.west_ref_termination_on, .osc_sync_pulse_r, .ref_pulse_r, .applied_adjust_delay,
	.sync_locked_flag);

//--- verif/sysref_pulse_gen.sv
// clock generator model that fires alignment reference pulses
`timescale 1ns/100ps
module sysref_pulse_gen #(
	parameter PW = 2         // pulse width in clocks
) (
	input  wire clk,         // dac clock
	input  wire fire,        // request one pulse
	input  wire east,        // pulse on east line when high
	output wire e_ref,       // east reference line
	output wire w_ref        // west reference line
);
	reg     side_r = 1'b0;   // line chosen for the pulse
	integer n = 0;           // clocks left in the pulse
	// lines rest low between pulses, so every pulse is a fresh edge
	always @(posedge clk) begin
		if (fire) begin
			n <= PW;
			side_r <= east;
		end else if (n > 0) n <= n - 1;
	end
	assign e_ref = (n > 0) && side_r;
	assign w_ref = (n > 0) && !side_r;
endmodule // sysref_pulse_gen

//--- verif/sysref_multi_device_sync_ctrl_bench.sv
// self-checking bench for the multiple-device sync control block
`timescale 1ns/100ps
module sysref_multi_device_sync_ctrl_bench;
	localparam [71:0] RA = 72'habaaa9a8a7a6a4a3a2; // control byte addresses
	localparam [71:0] RV = 72'h000000000000001000; // their reset values
	localparam [71:0] RM = 72'hffffffffff1fff7f35; // their writable masks
	localparam [47:0] EX = 48'h010100820002;       // offset latencies
	reg        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0; // clock, reset, strobes
	reg  [7:0] addr = 8'h00, wdata = 8'h00;  // register port
	reg  [3:0] det = 4'h0;                   // start late, start early, late, early
	reg        lockout = 1'b0, dv = 1'b0, fire = 1'b0, east = 1'b0; // stimulus
	wire [7:0] rdata, adj;                   // read data, applied delay
	wire       e_ref, w_ref, epw, wpw, etm, wtm, osc, refp, win, tick, dov, lock;
	integer    errors = 0, samples_checked = 0, i, n;
	sysref_pulse_gen sysref_pulse_gen_inst (.clk(clk), .fire(fire), .east(east),
		.e_ref(e_ref), .w_ref(w_ref));
	sysref_multi_device_sync_ctrl sysref_multi_device_sync_ctrl_inst (.clk(clk), .rst(rst),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_r(rdata),
		.east_ref_in(e_ref), .west_ref_in(w_ref), .early_det(det[0]), .late_det(det[1]),
		.start_early_det(det[2]), .start_late_det(det[3]), .lockout(lockout),
		.data_in_valid(dv), .east_ref_buffer_power(epw), .west_ref_buffer_power(wpw),
		.east_ref_termination_on(etm), .west_ref_termination_on(wtm),
		.osc_sync_pulse_r(osc), .ref_pulse_r(refp), .window_out_r(win),
		.mf_clock_tick_r(tick), .data_out_valid_r(dov), .applied_adjust_delay(adj),
		.sync_locked_flag(lock));
	// 100 MHz clock
	always #5 clk = ~clk;
	// compare and count
	task check(input [15:0] seen, input [15:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	// strobe held one edge, then a quiet edge so strobes never merge
	task wr_reg(input [7:0] a, input [7:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	// data lands after the taking edge and holds until the next read
	task rd_reg(input [7:0] a, input [7:0] exp);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(posedge clk);
			check(rdata, exp);
		end
	endtask
	// one reference pulse on the chosen line
	task shoot(input s);
		begin
			fire <= 1'b1;
			east <= s;
			@(posedge clk);
			fire <= 1'b0;
		end
	endtask
	// pulse, then see whether a reference and an oscillator pulse follow
	task ref_case(input [7:0] m, input [7:0] c, input s, input [1:0] e);
		begin
			wr_reg(8'ha3, m);
			wr_reg(8'ha0, c);
			shoot(s);
			for (n = 0; n < 8 && refp !== 1'b1; n = n + 1) @(negedge clk);
			@(negedge clk);
			check({n < 8, osc}, e);
			@(posedge clk);
		end
	endtask
	// bounded wait for the lock flag to reach a level
	task wait_lock(input v, input integer lim);
		begin
			@(negedge clk);
			for (n = 0; n < lim && lock !== v; n = n + 1) @(negedge clk);
			@(posedge clk);
		end
	endtask
	task pulse_lockout;
		begin
			lockout <= 1'b1;
			@(posedge clk);
			lockout <= 1'b0;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, errors);
			if (errors == 0 && samples_checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	// hang guard, 20k clocks
	initial begin
		#200000;
		errors = errors + 1;
		finish_test;
	end
	// test sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 9; i = i + 1) rd_reg(RA[8*i+:8], RV[8*i+:8]);
		rd_reg(8'hb5, 8'h00);
		rd_reg(8'hb8, 8'h00);
		$display("reset values done");
		wr_reg(8'hb5, 8'hff);
		rd_reg(8'hb5, 8'h00);
		wr_reg(8'hb0, 8'hff);
		rd_reg(8'hb0, 8'h00);
		for (i = 0; i < 9; i = i + 1) wr_reg(RA[8*i+:8], 8'hff);
		for (i = 0; i < 9; i = i + 1) rd_reg(RA[8*i+:8], RM[8*i+:8]);
		for (i = 0; i < 4; i = i + 1) begin
			wr_reg(8'ha2, 8'h01 << (16'h0245 >> (4 * i) & 15));
			@(posedge clk);
			check({epw, wpw, etm, wtm}, 8'h08 >> i);
		end
		$display("register access done");
		wr_reg(8'ha0, 8'h20);
		wr_reg(8'ha4, 8'h5a);
		rd_reg(8'hb5, 8'h5a);
		wr_reg(8'ha4, 8'ha5);
		rd_reg(8'hb5, 8'ha5);
		check(adj, 8'ha5);
		$display("manual delay done");
		ref_case(8'h40, 8'h29, 1'b1, 2'b11);
		ref_case(8'h40, 8'h29, 1'b0, 2'b00);
		ref_case(8'h00, 8'h21, 1'b0, 2'b10);
		$display("reference pulse done");
		for (i = 0; i < 3; i = i + 1) begin
			repeat (260) @(posedge clk); // let earlier strobes leave the line
			wr_reg(8'ha7, 24'h7f0080 >> (8 * i));
			dv <= 1'b1;
			@(posedge clk);
			dv <= 1'b0;
			@(negedge clk);
			for (n = 1; n < 300 && dov !== 1'b1; n = n + 1) @(negedge clk);
			check(n, EX[16*i+:16]);
			@(posedge clk);
		end
		$display("offset delay done");
		for (i = 0; i < 9; i = i + 1) wr_reg(RA[8*i+:8], 72'h02_01_03_03_00_12_30_00_30 >> (8 * i));
		for (i = 0; i < 4; i = i + 1) begin
			wr_reg(8'ha0, 8'h00);
			det <= 16'h6123 >> (4 * i);
			wr_reg(8'ha0, {i[1:0], 6'h09});
			shoot(1'b1);
			wait_lock(1'b1, 2000);
			check(lock, 1'b1);
			rd_reg(8'hb8, 8'h80);
			rd_reg(8'hb5, 8'h30);
		end
		pulse_lockout;
		wait_lock(1'b0, 20);
		wait_lock(1'b1, 2000);
		check(lock, 1'b1);
		wr_reg(8'ha6, 8'h02);
		pulse_lockout;
		wait_lock(1'b1, 300);
		check(lock, 1'b0);
		wr_reg(8'ha0, 8'h00);
		det <= 4'h2;
		wr_reg(8'ha0, 8'h89);
		shoot(1'b1);
		wait_lock(1'b1, 600);
		check({lock, adj !== 8'h30}, 2'b01);
		$display("lock sequence done");
		// window 5 low, 7 high; period 10; preset 5
		wr_reg(8'ha0, 8'h00);
		for (i = 0; i < 4; i = i + 1) wr_reg(8'ha8 + i, 32'h05_09_06_04 >> (8 * i));
		wr_reg(8'ha0, 8'h09);
		shoot(1'b1);
		for (n = 0; n < 8 && refp !== 1'b1; n = n + 1) @(negedge clk);
		repeat (2) @(negedge clk);
		for (n = 2; n < 300 && tick !== 1'b1; n = n + 1) @(negedge clk);
		check(n, 8);
		@(negedge clk);
		for (n = 1; n < 300 && tick !== 1'b1; n = n + 1) @(negedge clk);
		check(n, 10);
		for (n = 0; n < 300 && win !== 1'b0; n = n + 1) @(negedge clk);
		for (n = 0; n < 300 && win !== 1'b1; n = n + 1) @(negedge clk);
		for (n = 0; n < 300 && win === 1'b1; n = n + 1) @(negedge clk);
		check(n, 7);
		for (n = 0; n < 300 && win === 1'b0; n = n + 1) @(negedge clk);
		check(n, 5);
		@(posedge clk);
		$display("timing done");
		finish_test;
	end
endmodule // sysref_multi_device_sync_ctrl_bench
